// ---- hdl/tid_pkg.sv ----
package tid_pkg;
	// ------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------
	localparam int IR_W = 4;
	localparam logic [3:0] INS_EXTEST = 4'h0;
	localparam logic [3:0] INS_SAMPLE = 4'h1;
	localparam logic [3:0] INS_IDENT = 4'h2;
	localparam logic [3:0] INS_CLAMP = 4'h3;
	localparam logic [3:0] INS_FLOAT = 4'h4;
	localparam logic [3:0] INS_OFS_READ = 4'h7;
	localparam logic [3:0] INS_OFS_WRITE = 4'h8;
	localparam logic [3:0] INS_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// ------------------------------------------------------------
	// Register sizes and timing
	// ------------------------------------------------------------
	localparam int ID_W = 32;
	localparam int BSR_W = 8;
	localparam int OFS_W = 16;
	localparam int RESET_TMS_CNT = 5;
	localparam int CLK_MHZ = 100;
	localparam int TCK_PERIOD_NS = 160;
	localparam int TCK_HALF_CYC = (TCK_PERIOD_NS * CLK_MHZ) / 2000;
	// ------------------------------------------------------------
	// Controller register map (APB byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam int CTRL_GO = 0;
	localparam int CTRL_IR = 1;
	localparam int CTRL_TLR = 2;
	localparam int CTRL_TRST = 3;
	localparam int CTRL_LEN = 8;
	localparam int CTRL_LEN_W = 6;
	localparam int CTRL_INS = 16;
	typedef enum logic [3:0] {
		TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PADR, EX2DR, UPDR,
		SELIR, CAPIR, SHIR, EX1IR, PAIR, EX2IR, UPIR
	} tid_state_t;
	function automatic tid_state_t tid_next(input tid_state_t s, input logic tms);
		case (s)
			TLR: tid_next = tms ? TLR : RTI;
			RTI: tid_next = tms ? SELDR : RTI;
			SELDR: tid_next = tms ? SELIR : CAPDR;
			CAPDR: tid_next = tms ? EX1DR : SHDR;
			SHDR: tid_next = tms ? EX1DR : SHDR;
			EX1DR: tid_next = tms ? UPDR : PADR;
			PADR: tid_next = tms ? EX2DR : PADR;
			EX2DR: tid_next = tms ? UPDR : SHDR;
			UPDR: tid_next = tms ? SELDR : RTI;
			SELIR: tid_next = tms ? TLR : CAPIR;
			CAPIR: tid_next = tms ? EX1IR : SHIR;
			SHIR: tid_next = tms ? EX1IR : SHIR;
			EX1IR: tid_next = tms ? UPIR : PAIR;
			PAIR: tid_next = tms ? EX2IR : PAIR;
			EX2IR: tid_next = tms ? UPIR : SHIR;
			UPIR: tid_next = tms ? SELDR : RTI;
			default: tid_next = TLR;
		endcase
	endfunction
endpackage

// ---- hdl/tid_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface tid_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdoEn;
	logic trst_n;
	modport device (input tck, tms, tdi, trst_n, output tdo, tdoEn);
	modport host (output tck, tms, tdi, trst_n, input tdo, tdoEn);
endinterface
`default_nettype wire

// ---- hdl/tid_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module tid_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta <= '0;
			dout <= '0;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // tid_sync
`default_nettype wire

// ---- hdl/tid_device.sv ----
`timescale 1ns/100ps
`default_nettype none
module tid_device
	import tid_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Test link
	tid_link_if.device link,
	// Pin side of the boundary chain
	input wire logic [BSR_W-1:0] pinIn,
	input wire logic [BSR_W-1:0] coreOut,
	output logic [BSR_W-1:0] pinOut,
	output logic pinOutEn,
	input wire logic coreOutEn,
	// Threshold offset registers
	input wire logic [OFS_W-1:0] almostEmptyOffset,
	input wire logic [OFS_W-1:0] almostFullOffset,
	output logic [OFS_W-1:0] newAlmostEmptyOffset,
	output logic [OFS_W-1:0] newAlmostFullOffset,
	output logic offsetWrite,
	// Test mode and instruction view
	output logic testMode,
	output logic [IR_W-1:0] testInstruction
);
	// ------------------------------------------------------------
	// Pin synchronisation and edge finding
	// ------------------------------------------------------------
	logic tckS, tmsS, tdiS, trstS_n, tckD;
	tid_sync #(.W(4)) uSync (
		.clk(clk),
		.arst_n(arst_n),
		.din({link.tck, link.tms, link.tdi, link.trst_n}),
		.dout({tckS, tmsS, tdiS, trstS_n})
	);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tckD <= 1'b0;
		else
			tckD <= tckS;
	end
	wire tckRise = tckS && !tckD;
	wire tckFall = !tckS && tckD;

	// ------------------------------------------------------------
	// Controller state
	// ------------------------------------------------------------
	// Controller starts in reset here only because flops need a value;
	// the host must still reset the port before use
	tid_state_t state;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= TLR;
		else if (!trstS_n)
			state <= TLR;
		else if (tckRise)
			state <= tid_next(state, tmsS);
	end

	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	logic [IR_W-1:0] irShift;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irShift <= IR_CAPTURE;
		else if (tckRise && state == CAPIR)
			irShift <= IR_CAPTURE;
		else if (tckRise && state == SHIR)
			irShift <= {tdiS, irShift[IR_W-1:1]};
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			testInstruction <= INS_IDENT;
		else if (!trstS_n || state == TLR)
			testInstruction <= INS_IDENT;
		else if (tckFall && state == UPIR)
			testInstruction <= irShift;
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic selBsr, selId, selOfs, selBypass, drvFromBsr, floatAll;
	always_comb
	begin
		selBsr = 1'b0;
		selId = 1'b0;
		selOfs = 1'b0;
		drvFromBsr = 1'b0;
		floatAll = 1'b0;
		case (testInstruction)
			INS_EXTEST:
			begin
				selBsr = 1'b1;
				drvFromBsr = 1'b1;
			end
			INS_SAMPLE: selBsr = 1'b1;
			INS_IDENT: selId = 1'b1;
			INS_CLAMP: drvFromBsr = 1'b1;
			INS_FLOAT: floatAll = 1'b1;
			INS_OFS_READ, INS_OFS_WRITE: selOfs = 1'b1;
			default: selBsr = 1'b0;
		endcase
		selBypass = !(selBsr || selId || selOfs);
	end

	// ------------------------------------------------------------
	// Data registers; only the selected one captures or shifts
	// ------------------------------------------------------------
	logic [BSR_W-1:0] bsrShift, bsrHold;
	logic [ID_W-1:0] idShift;
	logic [2*OFS_W-1:0] ofsShift;
	logic bypassBit;
	wire capDr = tckRise && state == CAPDR;
	wire shDr = tckRise && state == SHDR;
	wire upDr = tckFall && state == UPDR;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bsrShift <= '0;
		else if (selBsr && capDr)
			bsrShift <= selBsr && drvFromBsr ? pinIn : coreOut;
		else if (selBsr && shDr)
			bsrShift <= {tdiS, bsrShift[BSR_W-1:1]};
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bsrHold <= '0;
		else if (selBsr && upDr)
			bsrHold <= bsrShift;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			idShift <= '0;
		else if (selId && capDr)
			idShift <= ID_VALUE;
		else if (selId && shDr)
			idShift <= {tdiS, idShift[ID_W-1:1]};
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ofsShift <= '0;
		else if (selOfs && capDr)
			ofsShift <= {almostFullOffset, almostEmptyOffset};
		else if (selOfs && shDr)
			ofsShift <= {tdiS, ofsShift[2*OFS_W-1:1]};
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bypassBit <= 1'b0;
		else if (selBypass && capDr)
			bypassBit <= 1'b0;
		else if (selBypass && shDr)
			bypassBit <= tdiS;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			newAlmostEmptyOffset <= '0;
			newAlmostFullOffset <= '0;
			offsetWrite <= 1'b0;
		end
		else
		begin
			offsetWrite <= 1'b0;
			if (testInstruction == INS_OFS_WRITE && upDr)
			begin
				newAlmostEmptyOffset <= ofsShift[OFS_W-1:0];
				newAlmostFullOffset <= ofsShift[2*OFS_W-1:OFS_W];
				offsetWrite <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial output, changes on the falling test clock
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			link.tdo <= 1'b0;
			link.tdoEn <= 1'b0;
		end
		else if (!trstS_n)
			link.tdoEn <= 1'b0;
		else if (tckFall)
		begin
			link.tdoEn <= state == SHIR || state == SHDR;
			if (state == SHIR)
				link.tdo <= irShift[0];
			else if (selId)
				link.tdo <= idShift[0];
			else if (selBsr)
				link.tdo <= bsrShift[0];
			else if (selOfs)
				link.tdo <= ofsShift[0];
			else
				link.tdo <= bypassBit;
		end
	end

	// ------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinOut <= '0;
			pinOutEn <= 1'b0;
			testMode <= 1'b0;
		end
		else
		begin
			pinOut <= drvFromBsr ? bsrHold : coreOut;
			pinOutEn <= floatAll ? 1'b0 : (drvFromBsr ? 1'b1 : coreOutEn);
			testMode <= drvFromBsr || floatAll;
		end
	end
endmodule // tid_device
`default_nettype wire

// ---- hdl/tid_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module tid_host
	import tid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Test link
	tid_link_if.host link,
	// Dedicated offset port and flag hold
	output logic offsetPortIdle,
	output logic flagHold
);
	typedef enum logic [2:0] {H_IDLE, H_HEAD, H_SHIFT, H_TAIL, H_RESET} tid_hstate_t;
	logic [CTRL_LEN_W-1:0] len, bitCnt;
	logic isIr, busy, tdoS, tdoSync;
	logic [31:0] wdata, rdata;
	logic [3:0] headCnt;
	logic [7:0] divCnt;
	tid_hstate_t hs;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	assign pready = 1'b1;
	tid_sync #(.W(1)) uSync (.clk(clk), .arst_n(arst_n), .din(link.tdo), .dout(tdoSync));
	assign tdoS = tdoSync;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wdata <= '0;
		else if (wr && paddr == REG_WDATA)
			wdata <= pwdata;
	end
	always_comb
	begin
		pslverr = 1'b0;
		prdata = '0;
		case (paddr)
			REG_CTRL: prdata = {26'h0, len};
			REG_STATUS: prdata = {31'h0, busy};
			REG_WDATA: prdata = wdata;
			REG_RDATA: prdata = rdata;
			default: pslverr = acc;
		endcase
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			link.trst_n <= 1'b0;
		else if (wr && paddr == REG_CTRL)
			link.trst_n <= !pwdata[CTRL_TRST];
	end

	// ------------------------------------------------------------
	// Test clock divider: edge pulses only while busy
	// ------------------------------------------------------------
	wire tickEdge = busy && divCnt == 8'(TCK_HALF_CYC - 1);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			divCnt <= '0;
		else if (!busy || tickEdge)
			divCnt <= '0;
		else
			divCnt <= divCnt + 8'h1;
	end
	wire riseNow = tickEdge && !link.tck;
	wire fallNow = tickEdge && link.tck;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			link.tck <= 1'b0;
		else if (tickEdge)
			link.tck <= !link.tck;
	end
	assign busy = hs != H_IDLE;

	// ------------------------------------------------------------
	// Scan sequencer: TMS changes on falling edges
	// ------------------------------------------------------------
	// Head: from idle, DR needs 1,0,0 and IR 1,1,0,0; tail after the last bit is 1,0,0
	// so the port always parks in run-test-idle, where every head starts
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hs <= H_IDLE;
			link.tms <= 1'b1;
			link.tdi <= 1'b0;
			len <= '0;
			bitCnt <= '0;
			headCnt <= '0;
			isIr <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			case (hs)
				H_IDLE:
					if (wr && paddr == REG_CTRL && pwdata[CTRL_TLR])
					begin
						hs <= H_RESET;
						link.tms <= 1'b1;
						headCnt <= '0;
					end
					else if (wr && paddr == REG_CTRL && pwdata[CTRL_GO])
					begin
						hs <= H_HEAD;
						isIr <= pwdata[CTRL_IR];
						len <= pwdata[CTRL_LEN +: CTRL_LEN_W];
						headCnt <= '0;
						link.tms <= 1'b1;
						rdata <= '0;
					end
				H_RESET:
					if (fallNow)
					begin
						headCnt <= headCnt + 4'h1;
						if (headCnt == 4'(RESET_TMS_CNT))
						begin
							link.tms <= 1'b0;
							hs <= H_TAIL;
							headCnt <= 4'h2;
						end
					end
				H_HEAD:
					if (fallNow)
					begin
						headCnt <= headCnt + 4'h1;
						link.tms <= isIr && headCnt == 4'h0;
						if (headCnt == (isIr ? 4'h3 : 4'h2))
						begin
							hs <= H_SHIFT;
							bitCnt <= '0;
							link.tdi <= isIr ? wdata[CTRL_INS] : wdata[0];
							link.tms <= len == 6'h1;
						end
					end
				H_SHIFT:
					if (riseNow)
						rdata <= {tdoS, rdata[31:1]};
					else if (fallNow)
					begin
						bitCnt <= bitCnt + 6'h1;
						link.tdi <= isIr ? wdata[CTRL_INS + 5'(bitCnt) + 1] : wdata[5'(bitCnt + 6'h1)];
						link.tms <= bitCnt + 6'h2 >= len;
						if (bitCnt + 6'h1 >= len)
						begin
							hs <= H_TAIL;
							headCnt <= '0;
							link.tms <= 1'b1;
						end
					end
				H_TAIL:
					if (fallNow)
					begin
						headCnt <= headCnt + 4'h1;
						link.tms <= 1'b0;
						if (headCnt == 4'h2)
							hs <= H_IDLE;
					end
				default: hs <= H_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			offsetPortIdle <= 1'b1;
			flagHold <= 1'b0;
		end
		else
		begin
			offsetPortIdle <= 1'b1;
			flagHold <= 1'b0;
		end
	end
endmodule // tid_host
`default_nettype wire

// ---- verification/tid_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module tid_asserts
	import tid_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Link wires
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdoEn,
	input wire logic trst_n
);
	// ------------------------------------------------------------
	// Reference walk, stepped on each sampled tck rise
	// ------------------------------------------------------------
	tid_state_t st;
	tid_state_t stPrev;
	logic tckQ;
	logic lastTdi;
	logic rise;
	logic inSh;
	logic wasSh;
	logic byp;
	logic [3:0] shIns;
	logic [3:0] curIns;
	logic [5:0] idx;
	assign rise = tck & ~tckQ;
	assign inSh = (st == SHDR) || (st == SHIR);
	assign wasSh = (stPrev == SHDR) || (stPrev == SHIR);
	// Unlisted codes fall back to the one-bit path
	assign byp = !(curIns inside {INS_EXTEST, INS_SAMPLE, INS_IDENT, INS_OFS_READ, INS_OFS_WRITE});
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tckQ <= 1'b0;
		else
			tckQ <= tck;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n || !trst_n)
		begin
			st <= TLR;
			stPrev <= TLR;
			curIns <= INS_IDENT;
		end
		else if (rise)
		begin
			stPrev <= st;
			st <= tid_next(st, tms);
			if (st == UPIR)
				curIns <= shIns;
			else if (st == TLR)
				curIns <= INS_IDENT;
		end
	end
	// Shift position only matters inside a shift, so it needs no reset
	always_ff @(posedge clk)
	begin
		if (rise)
		begin
			idx <= inSh ? idx + 6'h1 : 6'h00;
			lastTdi <= tdi;
			if (st == SHIR)
				shIns <= {tdi, shIns[3:1]};
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_quiet;
		rise && !inSh && !wasSh |-> !tdoEn;
	endproperty
	a_quiet: assert property (p_quiet) else $error("tdo driven outside shift");
	property p_drive;
		rise && inSh |-> tdoEn;
	endproperty
	a_drive: assert property (p_drive) else $error("tdo not driven in shift");
	property p_irCap;
		rise && st == SHIR && idx < 6'd4 |-> tdo == IR_CAPTURE[idx[1:0]];
	endproperty
	a_irCap: assert property (p_irCap) else $error("bad capture pattern");
	property p_ident;
		rise && st == SHDR && curIns == INS_IDENT && idx < 6'd32 |-> tdo == ID_VALUE[idx[4:0]];
	endproperty
	a_ident: assert property (p_ident) else $error("bad identification bit");
	property p_bypZero;
		rise && st == SHDR && byp && idx == 6'd0 |-> !tdo;
	endproperty
	a_bypZero: assert property (p_bypZero) else $error("bypass capture not zero");
	property p_bypPass;
		rise && st == SHDR && byp && idx != 6'd0 |-> tdo == lastTdi;
	endproperty
	a_bypPass: assert property (p_bypPass) else $error("bypass path broken");
	property p_trst;
		!trst_n [*4] |-> !tdoEn;
	endproperty
	a_trst: assert property (p_trst) else $error("tdo driven in test reset");
	property p_tdoFall;
		$changed(tdo) |-> !tck;
	endproperty
	a_tdoFall: assert property (p_tdoFall) else $error("tdo moved while tck high");
endmodule // tid_asserts
`default_nettype wire

// ---- verification/tap_instruction_decoder_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module tap_instruction_decoder_bench;
	import tid_pkg::*;
	typedef struct {logic [3:0] code; logic mode; logic [1:0] pins; logic [31:0] exp, mask;} tid_row_t;
	localparam logic [31:0] W = 32'ha5c3_96e1;
	localparam logic [31:0] ID = 32'h5a00_0c31; // arbitrary value
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, portIdle, flagHold, ofsWr, tMode, pinEn;
	logic [7:0] pinIn = 8'h3c, coreOut = 8'h96, pinOut;
	logic coreOutEn = 1'b1;
	logic [15:0] aeOfs = 16'h0123, afOfs = 16'h0fed, newAe, newAf;
	logic [3:0] tIns;
	int n_errors = 0, n_checks = 0, nWr = 0;
	tid_row_t rows[9];
	always #5 clk = ~clk;
	always @(posedge clk) if (ofsWr === 1'b1) nWr++;
	tid_link_if link ();
	tid_device #(.ID_VALUE(ID)) i_tid_device (.clk(clk), .arst_n(arst_n), .link(link),
		.pinIn(pinIn), .coreOut(coreOut), .pinOut(pinOut), .pinOutEn(pinEn),
		.coreOutEn(coreOutEn), .almostEmptyOffset(aeOfs), .almostFullOffset(afOfs),
		.newAlmostEmptyOffset(newAe), .newAlmostFullOffset(newAf), .offsetWrite(ofsWr),
		.testMode(tMode), .testInstruction(tIns));
	tid_host i_tid_host (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link), .offsetPortIdle(portIdle), .flagHold(flagHold));
	tid_asserts #(.ID_VALUE(ID)) i_tid_asserts (.clk(clk), .arst_n(arst_n), .tck(link.tck),
		.tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdoEn(link.tdoEn),
		.trst_n(link.trst_n));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Ends one idle cycle after the access so the next setup never collides
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_errors++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitIdle();
		int i;
		for (i = 0; i < 4000; i++)
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		if (i == 4000)
		begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic scan(input logic ir, input logic [3:0] code, input logic [31:0] d);
		// The host shifts the instruction from the data word, bits 19 to 16
		apb(1'b1, REG_WDATA, ir ? {12'h0, code, 16'h0} : d);
		apb(1'b1, REG_CTRL, {12'h0, code, 2'b00, ir ? 6'd4 : 6'd32, 6'h00, ir, 1'b1});
		waitIdle();
		apb(1'b0, REG_RDATA, 32'h0);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		int k;
		int w0;
		rows = '{'{INS_SAMPLE, 1'b0, 2'd0, {W[23:0], 8'h00}, 32'hffff_ff00},
			'{INS_EXTEST, 1'b1, 2'd1, {W[23:0], pinIn}, 32'hffff_ffff},
			'{INS_CLAMP, 1'b1, 2'd1, {W[30:0], 1'b0}, 32'hffff_ffff},
			'{INS_FLOAT, 1'b1, 2'd2, {W[30:0], 1'b0}, 32'hffff_ffff},
			'{INS_IDENT, 1'b0, 2'd0, ID, 32'hffff_ffff},
			'{INS_OFS_READ, 1'b0, 2'd0, {afOfs, aeOfs}, 32'hffff_ffff},
			'{INS_OFS_WRITE, 1'b0, 2'd0, {afOfs, aeOfs}, 32'hffff_ffff},
			'{INS_BYPASS, 1'b0, 2'd0, {W[30:0], 1'b0}, 32'hffff_ffff},
			'{4'h5, 1'b0, 2'd0, {W[30:0], 1'b0}, 32'hffff_ffff}};
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk("instr", INS_IDENT, tIns);
		chk("portIdle", 1'b1, portIdle);
		chk("flagHold", 1'b0, flagHold);
		// Scans start from run-test-idle, so walk the port there first
		apb(1'b1, REG_CTRL, 32'h4);
		waitIdle();
		scan(1'b0, 4'h0, W);
		chk("idScan", ID, rd);
		for (k = 0; k < 9; k++)
		begin
			w0 = nWr;
			scan(1'b1, rows[k].code, 32'h0);
			chk("irCap", IR_CAPTURE, rd[31:28]);
			scan(1'b0, 4'h0, W);
			if (k != 8)
				chk("instr", rows[k].code, tIns);
			chk("mode", rows[k].mode, tMode);
			chk("rdata", rows[k].exp, rd & rows[k].mask);
			chk("ofsWrites", rows[k].code == INS_OFS_WRITE, nWr - w0);
			if (rows[k].pins == 2'd1)
				chk("pinOut", W[31:24], pinOut);
			else if (rows[k].pins == 2'd0)
				chk("pinOut", coreOut, pinOut);
			chk("pinEn", rows[k].pins == 2'd1 || (rows[k].pins == 2'd0 && coreOutEn), pinEn);
		end
		chk("newAf", W[31:16], newAf);
		chk("newAe", W[15:0], newAe);
		// Six tms-high clocks, then the test reset wire, each from bypass
		scan(1'b1, INS_BYPASS, 32'h0);
		apb(1'b1, REG_CTRL, 32'h5);
		waitIdle();
		chk("instr", INS_IDENT, tIns);
		scan(1'b1, INS_BYPASS, 32'h0);
		apb(1'b1, REG_CTRL, 32'h8);
		apb(1'b0, 8'h40, 32'h0);
		chk("slvErr", 1'b1, err);
		chk("instr", INS_IDENT, tIns);
		apb(1'b1, REG_CTRL, 32'h4);
		waitIdle();
		scan(1'b0, 4'h0, W);
		chk("idScan", ID, rd);
		scan(1'b1, INS_CLAMP, 32'h0);
		chk("mode", 1'b1, tMode);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk("instr", INS_IDENT, tIns);
		chk("mode", 1'b0, tMode);
		conclude();
	end
endmodule // tap_instruction_decoder_bench
`default_nettype wire
